// ### include/ccsr_pkg.sv
// constants for the cpu control/status register block
// assumes a single cpu clock and a 5-bit control-register move address
package ccsr_pkg;
	// ==================================================
	// move addresses
	localparam logic [4:0] CCSR_ADDR_AMC = 5'h00;
	localparam logic [4:0] CCSR_ADDR_CAS = 5'h01;
	localparam logic [4:0] CCSR_ADDR_IFR = 5'h02;
	localparam logic [4:0] CCSR_ADDR_ICL = 5'h03;
	localparam logic [4:0] CCSR_ADDR_IEM = 5'h04;
	// ==================================================
	// field positions
	localparam int CCSR_BK1_LSB   = 21;
	localparam int CCSR_BK0_LSB   = 16;
	localparam int CCSR_ID_LSB    = 24;
	localparam int CCSR_REV_LSB   = 16;
	localparam int CCSR_PD_LSB    = 10;
	localparam int CCSR_SAT_BIT   = 9;
	localparam int CCSR_EN_BIT    = 8;
	localparam int CCSR_PCC_LSB   = 5;
	localparam int CCSR_DCC_LSB   = 2;
	localparam int CCSR_PREVIOUS_GLOBAL_ENABLE_BIT  = 1;
	localparam int CCSR_GIE_BIT   = 0;
	localparam int CCSR_NONMASKABLE_ENABLE_BIT  = 1;
	localparam int CCSR_MI_LSB    = 4;
	localparam int CCSR_MI_N      = 12;
	localparam int CCSR_NREG      = 5;
	// ==================================================
	// encodings and reset values
	localparam logic [1:0] CCSR_MODE_LIN  = 2'h0;
	localparam logic [1:0] CCSR_MODE_BK0  = 2'h1;
	localparam logic [1:0] CCSR_MODE_BK1  = 2'h2;
	localparam logic [4:0] CCSR_BK_LINEAR = 5'h1F;
	localparam logic [5:0] CCSR_PD_NONE   = 6'h00;
	localparam logic [5:0] CCSR_PD1_EN    = 6'h09;
	localparam logic [5:0] CCSR_PD1_ANY   = 6'h11;
	localparam logic [5:0] CCSR_PD2       = 6'h1A;
	localparam logic [5:0] CCSR_PD3       = 6'h1C;
	localparam logic [2:0] CCSR_CACHE_A   = 3'h0;
	localparam logic [2:0] CCSR_CACHE_B   = 3'h2;
	localparam logic [31:0] CCSR_RST_ZERO = 32'h0000_0000;
	localparam logic [1:0] CCSR_RST_CSR_LO = 2'h0;
	typedef enum logic [1:0] {CCSR_PWR_RUN, CCSR_PWR_L1, CCSR_PWR_L2, CCSR_PWR_L3} ccsr_pwr_e;
endpackage

// ### verilog/ccsr_amode_dec.sv
// address-mode decoder for one register: mode field plus block sizes
// assumes fields come straight from the address mode register
`timescale 1ns/1ps
module ccsr_amode_dec
	import ccsr_pkg::*;
(
	input  wire logic [1:0] i_mode,
	input  wire logic [4:0] i_bk0,
	input  wire logic [4:0] i_bk1,
	output logic            o_circ,
	output logic [5:0]      o_log2_size,
	output logic            o_reserved
);
	logic [4:0] bk;

	always_comb begin
		bk          = (i_mode == CCSR_MODE_BK1) ? i_bk1 : i_bk0;
		o_reserved  = (i_mode == 2'h3);
		// an all-ones code collapses to linear behaviour
		o_circ      = ((i_mode == CCSR_MODE_BK0) || (i_mode == CCSR_MODE_BK1))
			&& (bk != CCSR_BK_LINEAR);
		o_log2_size = {1'b0, bk} + 6'h01;
	end
endmodule

// ### verilog/ccsr_regs.sv
// cpu control register bank: address mode, control/status, clear, enable
// assumes a control-register move port on the cpu clock; flags live outside
// What this block does
// - mode field: linear, circular bk0/bk1, reserved
// - mode fields at bits 1-0 to 9-8
// - block size two to power code plus one
// - all-ones block code acts linear
// - identity and revision fields are read-only
// - power code zero, 9h and 11h meanings
// - codes 1Ah, 1Ch deep power-down, reset exits
// - saturation set by unit, set wins
// - saturation sets two cycles after event
// - false-condition ops leave saturation alone
// - endian bit read-only, 1 is little
// - program cache codes 0 and 2h valid
// - data cache codes 0 and 2h valid
// - interrupt taken copies global into previous
// - global enable clear blocks maskable interrupts
// - writing one to clear bit clears flag
// - arriving interrupt beats same-cycle clear
// - clear visible to flag read two cycles later
// - set beats clear at same bit
// - per-interrupt enable gates processing
// - nonmaskable enable set-only, cleared by nmi
// - nonmaskable enable low blocks all nonreset
// - enable bit zero always reads one
// - move addresses 0,1,3,4 select registers
// - move access completes in first execute phase
`timescale 1ns/1ps
module ccsr_regs
	import ccsr_pkg::*;
#(
	parameter logic [7:0] PROC_ID  = 8'h5A, // arbitrary value
	parameter logic [7:0] SIL_REV  = 8'h01, // arbitrary value
	parameter int         NAREG    = 5
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_nrst,
	input  wire logic                 i_little_endian,
	input  wire logic                 i_mv_wr,
	input  wire logic                 i_mv_rd,
	input  wire logic [4:0]           i_mv_addr,
	input  wire logic [31:0]          i_mv_wdata,
	output logic [31:0]               o_mv_rdata,
	input  wire logic                 i_sat_event,
	input  wire logic                 i_sat_cond,
	input  wire logic                 i_int_taken,
	input  wire logic                 i_nmi_taken,
	input  wire logic                 i_nrp_return,
	input  wire logic                 i_irp_return,
	input  wire logic [CCSR_MI_N-1:0] i_flag_set,
	input  wire logic [CCSR_MI_N-1:0] i_int_pend,
	input  wire logic                 i_nmi_pend,
	output logic [CCSR_MI_N-1:0]      o_flag_clear,
	output logic [CCSR_MI_N-1:0]      o_int_allow,
	output logic                      o_nmi_allow,
	output logic [NAREG-1:0]          o_circ,
	output logic [NAREG*6-1:0]        o_log2_size,
	output logic [NAREG-1:0]          o_mode_rsvd,
	output logic [5:0]                o_pd_code,
	output ccsr_pwr_e                 o_pwr_state,
	output logic                      o_pd_wake_any,
	output logic                      o_pcc_valid,
	output logic                      o_dcc_valid,
	output logic                      o_little_endian
);
	// ==================================================
	// state
	logic [2*NAREG-1:0]   amode_q, amode_d;
	logic [4:0]           bk0_q, bk0_d, bk1_q, bk1_d;
	logic [5:0]           pd_q, pd_d;
	logic                 sat_q, sat_d, sat_pend_q, sat_pend_d;
	logic [2:0]           pcc_q, pcc_d, dcc_q, dcc_d;
	logic                 previous_global_enable_q, previous_global_enable_d, gie_q, gie_d;
	logic [CCSR_MI_N-1:0] ien_q, ien_d, clr_q, clr_d;
	logic                 nonmaskable_enable_q, nonmaskable_enable_d;
	logic                 en_sync1_q, en_sync2_q, en_q;
	logic [31:0]          rdata_q, rdata_d;
	ccsr_pwr_e            pwr_q, pwr_d;
	logic                 wr_amc, wr_cas, wr_icl, wr_iem;

	assign wr_amc = i_mv_wr && (i_mv_addr == CCSR_ADDR_AMC);
	assign wr_cas = i_mv_wr && (i_mv_addr == CCSR_ADDR_CAS);
	assign wr_icl = i_mv_wr && (i_mv_addr == CCSR_ADDR_ICL);
	assign wr_iem = i_mv_wr && (i_mv_addr == CCSR_ADDR_IEM);

	// ==================================================
	// address decode per register
	genvar g;
	generate
		for (g = 0; g < NAREG; g++) begin : g_dec
			ccsr_amode_dec u_dec (
				.i_mode      (amode_q[2*g +: 2]),
				.i_bk0       (bk0_q),
				.i_bk1       (bk1_q),
				.o_circ      (o_circ[g]),
				.o_log2_size (o_log2_size[6*g +: 6]),
				.o_reserved  (o_mode_rsvd[g])
			);
		end
	endgenerate

	// ==================================================
	// next-state
	always_comb begin
		amode_d    = amode_q;
		bk0_d      = bk0_q;
		bk1_d      = bk1_q;
		pd_d       = pd_q;
		pcc_d      = pcc_q;
		dcc_d      = dcc_q;
		previous_global_enable_d     = previous_global_enable_q;
		gie_d      = gie_q;
		ien_d      = ien_q;
		nonmaskable_enable_d     = nonmaskable_enable_q;
		pwr_d      = pwr_q;
		if (wr_amc) begin
			amode_d = i_mv_wdata[2*NAREG-1:0];
			bk0_d   = i_mv_wdata[CCSR_BK0_LSB +: 5];
			bk1_d   = i_mv_wdata[CCSR_BK1_LSB +: 5];
		end
		if (wr_cas) begin
			pd_d   = i_mv_wdata[CCSR_PD_LSB +: 6];
			pcc_d  = i_mv_wdata[CCSR_PCC_LSB +: 3];
			dcc_d  = i_mv_wdata[CCSR_DCC_LSB +: 3];
			previous_global_enable_d = i_mv_wdata[CCSR_PREVIOUS_GLOBAL_ENABLE_BIT];
			gie_d  = i_mv_wdata[CCSR_GIE_BIT];
		end
		if (i_irp_return)
			gie_d = previous_global_enable_q;
		if (i_int_taken) begin
			previous_global_enable_d = gie_q;
			gie_d  = 1'b0;
		end
		if (wr_iem) begin
			ien_d = i_mv_wdata[CCSR_MI_LSB +: CCSR_MI_N];
			if (i_mv_wdata[CCSR_NONMASKABLE_ENABLE_BIT])
				nonmaskable_enable_d = 1'b1;
		end
		if (i_nrp_return)
			nonmaskable_enable_d = 1'b1;
		if (i_nmi_taken)
			nonmaskable_enable_d = 1'b0;
		// an interrupt wakes the core from the light level only
		unique case (pwr_q)
			CCSR_PWR_RUN: begin
				if (pd_d == CCSR_PD1_EN || pd_d == CCSR_PD1_ANY)
					pwr_d = CCSR_PWR_L1;
				else if (pd_d == CCSR_PD2)
					pwr_d = CCSR_PWR_L2;
				else if (pd_d == CCSR_PD3)
					pwr_d = CCSR_PWR_L3;
			end
			CCSR_PWR_L1: begin
				if ((pd_q == CCSR_PD1_ANY) ? ((|i_int_pend) || i_nmi_pend)
					: ((|o_int_allow) || o_nmi_allow)) begin
					pwr_d = CCSR_PWR_RUN;
					pd_d  = CCSR_PD_NONE;
				end
			end
			CCSR_PWR_L2: pwr_d = CCSR_PWR_L2;
			CCSR_PWR_L3: pwr_d = CCSR_PWR_L3;
		endcase
	end

	// saturation: set one cycle late, set wins over move clear
	always_comb begin
		sat_pend_d = i_sat_event && i_sat_cond;
		sat_d      = sat_q;
		if (wr_cas && !i_mv_wdata[CCSR_SAT_BIT])
			sat_d = 1'b0;
		if (sat_pend_q)
			sat_d = 1'b1;
	end

	// clear strobes reach the flag register one cycle after the move,
	// so the flag read sees it two cycles later; set and arrival win
	always_comb begin
		clr_d = wr_icl ? i_mv_wdata[CCSR_MI_LSB +: CCSR_MI_N] : '0;
	end
	assign o_flag_clear = clr_q & ~i_flag_set;

	// ==================================================
	// interrupt gating
	assign o_int_allow = i_int_pend & ien_q & {CCSR_MI_N{gie_q && nonmaskable_enable_q}};
	assign o_nmi_allow = i_nmi_pend && nonmaskable_enable_q;

	// ==================================================
	// read mux; reserved bits zero
	always_comb begin
		rdata_d = CCSR_RST_ZERO;
		if (i_mv_rd) begin
			unique case (i_mv_addr)
				CCSR_ADDR_AMC: begin
					rdata_d[2*NAREG-1:0]        = amode_q;
					rdata_d[CCSR_BK0_LSB +: 5]  = bk0_q;
					rdata_d[CCSR_BK1_LSB +: 5]  = bk1_q;
				end
				CCSR_ADDR_CAS: begin
					rdata_d[CCSR_ID_LSB +: 8]   = PROC_ID;
					rdata_d[CCSR_REV_LSB +: 8]  = SIL_REV;
					rdata_d[CCSR_PD_LSB +: 6]   = pd_q;
					rdata_d[CCSR_SAT_BIT]       = sat_q;
					rdata_d[CCSR_EN_BIT]        = en_q;
					rdata_d[CCSR_PCC_LSB +: 3]  = pcc_q;
					rdata_d[CCSR_DCC_LSB +: 3]  = dcc_q;
					rdata_d[CCSR_PREVIOUS_GLOBAL_ENABLE_BIT]      = previous_global_enable_q;
					rdata_d[CCSR_GIE_BIT]       = gie_q;
				end
				CCSR_ADDR_IEM: begin
					rdata_d[CCSR_MI_LSB +: CCSR_MI_N] = ien_q;
					rdata_d[CCSR_NONMASKABLE_ENABLE_BIT]      = nonmaskable_enable_q;
					rdata_d[0]                  = 1'b1;
				end
				default: rdata_d = CCSR_RST_ZERO;
			endcase
		end
	end

	// ==================================================
	// registers
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			amode_q    <= '0;
			bk0_q      <= '0;
			bk1_q      <= '0;
			pd_q       <= CCSR_PD_NONE;
			sat_q      <= 1'b0;
			sat_pend_q <= 1'b0;
			pcc_q      <= CCSR_CACHE_A;
			dcc_q      <= CCSR_CACHE_A;
			previous_global_enable_q     <= 1'b0;
			gie_q      <= 1'b0;
			ien_q      <= '0;
			nonmaskable_enable_q     <= 1'b0;
			clr_q      <= '0;
			rdata_q    <= CCSR_RST_ZERO;
			pwr_q      <= CCSR_PWR_RUN;
			en_sync1_q <= 1'b0;
			en_sync2_q <= 1'b0;
			en_q       <= 1'b0;
		end else begin
			amode_q    <= amode_d;
			bk0_q      <= bk0_d;
			bk1_q      <= bk1_d;
			pd_q       <= pd_d;
			sat_q      <= sat_d;
			sat_pend_q <= sat_pend_d;
			pcc_q      <= pcc_d;
			dcc_q      <= dcc_d;
			previous_global_enable_q     <= previous_global_enable_d;
			gie_q      <= gie_d;
			ien_q      <= ien_d;
			nonmaskable_enable_q     <= nonmaskable_enable_d;
			clr_q      <= clr_d;
			rdata_q    <= rdata_d;
			pwr_q      <= pwr_d;
			// the endian strap is a pin, so it is synchronised
			en_sync1_q <= i_little_endian;
			en_sync2_q <= en_sync1_q;
			en_q       <= en_sync2_q;
		end
	end

	// ==================================================
	// outputs
	assign o_mv_rdata      = rdata_q;
	assign o_pd_code       = pd_q;
	assign o_pwr_state     = pwr_q;
	assign o_pd_wake_any   = (pd_q == CCSR_PD1_ANY);
	assign o_pcc_valid     = (pcc_q == CCSR_CACHE_A) || (pcc_q == CCSR_CACHE_B);
	assign o_dcc_valid     = (dcc_q == CCSR_CACHE_A) || (dcc_q == CCSR_CACHE_B);
	assign o_little_endian = en_q;

	// ==================================================
	// checks
	AST_SAT_LATE: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(i_sat_event && i_sat_cond) |-> ##2 sat_q)
		else $error("saturation flag not set two edges after event");
	AST_SAT_FALSE: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(!sat_q && !sat_pend_q && !(i_sat_event && i_sat_cond)) |=> !sat_q)
		else $error("saturation flag set without a true event");
	AST_CLR_DELAY: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(wr_icl && i_mv_wdata[CCSR_MI_LSB]) |=> (clr_q[0]))
		else $error("clear strobe not issued one cycle after write");
	AST_SET_WINS: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(i_flag_set != '0) |-> ((o_flag_clear & i_flag_set) == '0))
		else $error("clear issued to a bit being set");
	AST_GIE_BLOCK: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!gie_q |-> (o_int_allow == '0))
		else $error("maskable interrupt allowed with global enable clear");
	AST_NONMASKABLE_ENABLE_BLOCK: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!nonmaskable_enable_q |-> (o_int_allow == '0 && !o_nmi_allow))
		else $error("interrupt allowed with nonmaskable enable clear");
	AST_NONMASKABLE_ENABLE_STICKY: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(nonmaskable_enable_q && !i_nmi_taken) |=> nonmaskable_enable_q)
		else $error("nonmaskable enable cleared without an nmi");
	AST_PREVIOUS_GLOBAL_ENABLE_COPY: assert property (@(posedge i_clk) disable iff (!i_nrst)
		i_int_taken |=> (previous_global_enable_q == $past(gie_q) && !gie_q))
		else $error("previous enable not copied on interrupt");
	AST_DEEP_PD: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(pwr_q == CCSR_PWR_L3) |=> (pwr_q == CCSR_PWR_L3))
		else $error("deep power-down left without reset");
	AST_IER_BIT0: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(i_mv_rd && i_mv_addr == CCSR_ADDR_IEM) |=> o_mv_rdata[0])
		else $error("enable register bit zero read as zero");
endmodule

// ### tb/ccsr_flag_model.sv
// flag register model that stands outside the control register block
// assumes flag sets and clear strobes arrive on the cpu clock
`timescale 1ns/1ps
module ccsr_flag_model
	import ccsr_pkg::*;
(
	input  wire logic [0:0]           i_clk,
	input  wire logic                 i_nrst,
	input  wire logic [CCSR_MI_N-1:0] i_set,
	input  wire logic [CCSR_MI_N-1:0] i_clear,
	output logic      [CCSR_MI_N-1:0] o_flags
);
	// ==================================================
	// flags
	// a set of the same bit wins, as an arriving interrupt would
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_flags <= '0;
		end else begin
			o_flags <= (o_flags & ~i_clear) | i_set;
		end
	end
endmodule

// ### tb/ccsr_regs_bench.sv
// self-checking bench for the cpu control register bank
// assumes the flag register model closes the clear and pending loop
`timescale 1ns/1ps
module ccsr_regs_bench
	import ccsr_pkg::*;
;
	localparam logic [7:0] PID = 8'h3C; // arbitrary value
	localparam logic [7:0] REV = 8'h07; // arbitrary value
	logic        i_clk, i_nrst, i_le, wr, rd, rd_d, se, sc, it, nt, nr, ir, np;
	logic [4:0]  addr, circ, mrsvd;
	logic [31:0] wd, rdata;
	logic [11:0] fset, pend, fclr, iallow;
	logic [29:0] l2s;
	logic [5:0]  pdc;
	logic        nallow, wake, pccv, dccv, le_o;
	ccsr_pwr_e   pst;
	logic [31:0] exp_q[$];
	int          error_cnt, n_tests, cyc;

	ccsr_regs #(.PROC_ID(PID), .SIL_REV(REV), .NAREG(5)) dut_u (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_little_endian(i_le), .i_mv_wr(wr), .i_mv_rd(rd), .i_mv_addr(addr), .i_mv_wdata(wd),
		.o_mv_rdata(rdata), .i_sat_event(se), .i_sat_cond(sc), .i_int_taken(it),
		.i_nmi_taken(nt), .i_nrp_return(nr), .i_irp_return(ir), .i_flag_set(fset),
		.i_int_pend(pend), .i_nmi_pend(np), .o_flag_clear(fclr), .o_int_allow(iallow),
		.o_nmi_allow(nallow), .o_circ(circ), .o_log2_size(l2s), .o_mode_rsvd(mrsvd),
		.o_pd_code(pdc), .o_pwr_state(pst), .o_pd_wake_any(wake), .o_pcc_valid(pccv),
		.o_dcc_valid(dccv), .o_little_endian(le_o));
	ccsr_flag_model flag_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_set(fset), .i_clear(fclr),
		.o_flags(pend));

	// ==================================================
	// clock, watchdog and read monitor
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		rd_d <= rd;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			results();
		end
	end
	// read data stands one cycle only, so it is judged mid-cycle
	always @(negedge i_clk) begin
		if (rd_d && exp_q.size() > 0) begin
			chk("rdata", exp_q.pop_front(), rdata);
		end
	end

	// ==================================================
	// tasks
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic mv(input logic [4:0] a, input logic [31:0] d, input logic w, input logic s);
		@(posedge i_clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wd <= d;
		se <= s;
		sc <= s;
		@(posedge i_clk);
		wr <= 0;
		rd <= 0;
		se <= 0;
		sc <= 0;
	endtask
	task automatic rdc(input logic [4:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		mv(a, 32'h0000_0000, 0, 0);
	endtask
	// 0 nmi taken, 1 nmi return, 2 interrupt taken, 3 interrupt return
	task automatic pulse(input int s);
		@(posedge i_clk);
		case (s)
			0: nt <= 1;
			1: nr <= 1;
			2: it <= 1;
			default: ir <= 1;
		endcase
		@(posedge i_clk);
		{nt, nr, it, ir} <= 4'h0;
	endtask
	task automatic do_reset();
		@(posedge i_clk);
		i_nrst <= 0;
		repeat (4) @(posedge i_clk);
		i_nrst <= 1;
		// endian pin passes a three-flop synchroniser
		repeat (4) @(posedge i_clk);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ==================================================
	// sequence
	initial begin
		logic [4:0]  bk0, bk1, bk;
		logic [9:0]  m;
		logic [5:0]  pd;
		logic [31:0] d, base;
		logic [11:0] e, r, c;
		logic        cir;
		{i_clk, i_nrst, wr, rd, rd_d, se, sc, it, nt, nr, ir, np} = '0;
		{addr, wd, fset, cyc, error_cnt, n_tests} = '0;
		i_le = 1;
		base = {PID, REV, 16'h0100};
		void'($urandom(32'hd9372eb7));
		do_reset();
		chk("le", 1, le_o);
		rdc(CCSR_ADDR_AMC, 32'h0000_0000);
		rdc(CCSR_ADDR_CAS, base);
		rdc(CCSR_ADDR_IEM, 32'h0000_0001);
		rdc(5'h1F, 32'h0000_0000);
		for (int k = 0; k < 4; k++) begin
			bk0 = (k == 3) ? CCSR_BK_LINEAR : 5'($urandom);
			bk1 = 5'($urandom);
			for (int i = 0; i < 5; i++) m[2*i+:2] = 2'(i + k);
			d = {6'h3F, bk1, bk0, 6'h00, m};
			mv(CCSR_ADDR_AMC, d, 1, 0);
			@(negedge i_clk);
			for (int i = 0; i < 5; i++) begin
				bk = (m[2*i+:2] == CCSR_MODE_BK0) ? bk0 : bk1;
				cir = (m[2*i+:2] inside {CCSR_MODE_BK0, CCSR_MODE_BK1}) && bk != CCSR_BK_LINEAR;
				chk("circ", cir, circ[i]);
				chk("rsvd", m[2*i+:2] == 2'h3, mrsvd[i]);
				if (cir) chk("size", 32'(bk) + 1, l2s[6*i+:6]);
			end
			rdc(CCSR_ADDR_AMC, d & 32'h03FF_03FF);
		end
		for (int k = 0; k < 8; k++) begin
			pd = (k == 1) ? CCSR_PD1_EN : (k == 2) ? CCSR_PD1_ANY : CCSR_PD_NONE;
			mv(CCSR_ADDR_CAS, {16'hFFFF, pd, 2'b00, 3'(k), 3'(7 - k), 2'b00}, 1, 0);
			@(negedge i_clk);
			chk("pcc", k == 0 || k == 2, pccv);
			chk("dcc", k == 7 || k == 5, dccv);
			chk("pd", pd, pdc);
			chk("wake", pd == CCSR_PD1_ANY, wake);
			if (pd != 0) chk("pwr", CCSR_PWR_L1, pst);
			rdc(CCSR_ADDR_CAS, {PID, REV, pd, 2'b01, 3'(k), 3'(7 - k), 2'b00});
		end
		mv(CCSR_ADDR_CAS, 32'h0000_0000, 1, 0);
		@(posedge i_clk);
		se <= 1;
		@(posedge i_clk);
		se <= 0;
		rdc(CCSR_ADDR_CAS, base);
		exp_q.push_back(base);
		mv(CCSR_ADDR_CAS, 0, 0, 1);
		rdc(CCSR_ADDR_CAS, base | 32'h0000_0200);
		mv(CCSR_ADDR_CAS, 32'h0000_0000, 1, 1);
		rdc(CCSR_ADDR_CAS, base | 32'h0000_0200);
		mv(CCSR_ADDR_CAS, 32'h0000_0000, 1, 0);
		rdc(CCSR_ADDR_CAS, base);
		mv(CCSR_ADDR_IEM, 32'hFFFF_FFFF, 1, 0);
		rdc(CCSR_ADDR_IEM, 32'h0000_FFF3);
		mv(CCSR_ADDR_IEM, 32'h0000_0000, 1, 0);
		rdc(CCSR_ADDR_IEM, 32'h0000_0003);
		pulse(0);
		rdc(CCSR_ADDR_IEM, 32'h0000_0001);
		pulse(1);
		e = 12'($urandom);
		r = 12'($urandom);
		mv(CCSR_ADDR_IEM, {16'h0000, e, 4'h0}, 1, 0);
		mv(CCSR_ADDR_CAS, 32'h0000_0001, 1, 0);
		@(posedge i_clk);
		fset <= r;
		np <= 1;
		@(posedge i_clk);
		fset <= 0;
		@(negedge i_clk);
		chk("allow", r & e, iallow);
		chk("nmi", 1, nallow);
		mv(CCSR_ADDR_CAS, 32'h0000_0000, 1, 0);
		@(negedge i_clk);
		chk("allow", 0, iallow);
		mv(CCSR_ADDR_CAS, 32'h0000_0001, 1, 0);
		pulse(0);
		@(negedge i_clk);
		chk("allow", 0, iallow);
		chk("nmi", 0, nallow);
		pulse(1);
		pulse(2);
		rdc(CCSR_ADDR_CAS, base | 32'h0000_0002);
		pulse(3);
		rdc(CCSR_ADDR_CAS, base | 32'h0000_0003);
		c = 12'($urandom) | 12'h001;
		@(posedge i_clk);
		wr <= 1;
		addr <= CCSR_ADDR_ICL;
		wd <= {16'hFFFF, c, 4'hF};
		@(posedge i_clk);
		wr <= 0;
		fset <= 12'h001;
		@(negedge i_clk);
		chk("clear", c & 12'hFFE, fclr);
		@(posedge i_clk);
		fset <= 0;
		@(negedge i_clk);
		chk("allow", ((r & ~c) | 12'h001) & e, iallow);
		for (int k = 0; k < 2; k++) begin
			pd = k ? CCSR_PD3 : CCSR_PD2;
			mv(CCSR_ADDR_CAS, {16'h0000, pd, 10'h000}, 1, 0);
			mv(CCSR_ADDR_CAS, 32'h0000_0000, 1, 0);
			@(negedge i_clk);
			chk("pwr", k ? CCSR_PWR_L3 : CCSR_PWR_L2, pst);
			do_reset();
			chk("pwr", CCSR_PWR_RUN, pst);
		end
		// strap low: the bit follows the pin, a move write of one is ignored
		i_le <= 0;
		repeat (4) @(posedge i_clk);
		@(negedge i_clk);
		chk("le", 0, le_o);
		mv(CCSR_ADDR_CAS, 32'h0000_0100, 1, 0);
		rdc(CCSR_ADDR_CAS, {PID, REV, 16'h0000});
		results();
	end
endmodule
